// File: lss_limit_switch_supervisor.sv
// Purpose: Four-switch travel limit supervision with latched slow and stop
// Assumes: Switch pins asynchronous, low means hit; other inputs on i_clk
// Notes: Speed reference is percent magnitude, direction is separate
`timescale 1ns/100ps
module lss_limit_switch_supervisor
  import lss_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Switch pins, high is voltage present: stop B, slow B, slow A, stop A
  input wire logic i_stop_b_pin,
  input wire logic i_slow_b_pin,
  input wire logic i_slow_a_pin,
  input wire logic i_stop_a_pin,
  // Configuration
  input wire logic [3:0] i_input_fitted_setting,
  input wire logic [1:0] i_switch_arrangement_select,
  input wire logic [6:0] i_slowdown_speed_percent,
  input wire logic i_accel_mode,
  // Master switch
  input wire logic i_dir_a,
  input wire logic i_dir_b,
  input wire logic [6:0] i_speed_ref_percent,
  // Outputs
  output logic [6:0] o_speed_ref_percent,
  output logic o_stop_a_n,
  output logic o_slow_a_n,
  output logic o_stop_b_n,
  output logic o_slow_b_n,
  output logic o_fault,
  output logic o_speed_mode
);
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync1_d;
  logic [3:0] sync2_d;
  logic [3:0] hit;
  logic stop_a_q, slow_a_q, stop_b_q, slow_b_q, fault_q;
  logic stop_a_d, slow_a_d, stop_b_d, slow_b_d, fault_d;
  logic [6:0] ref_q;
  logic [6:0] ref_d;
  lss_mode_t mode_q;
  lss_mode_t mode_d;
  logic neutral;
  logic bad;
  logic [2:0] nhit;

  always_comb
  begin
    sync1_d = {i_stop_b_pin, i_slow_b_pin, i_slow_a_pin, i_stop_a_pin};
    sync2_d = sync1_q;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      sync1_q <= LSS_SYNC_RESET;
      sync2_q <= LSS_SYNC_RESET;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  // Hit decode per switch
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_hit
      assign hit[g] = ~sync2_q[g] & i_input_fitted_setting[g] &
        (i_switch_arrangement_select != LSS_ARR_BYPASS);
    end
  endgenerate

  // Bit order: 3 stop B, 2 slow B, 1 slow A, 0 stop A
  always_comb
  begin
    nhit = {2'h0, hit[0]} + {2'h0, hit[1]} + {2'h0, hit[2]} + {2'h0, hit[3]};
    bad = (nhit >= 3'h3)
      | (hit[1] & hit[3]) | (hit[2] & hit[0])
      | (hit[1] & hit[2]) | (hit[3] & hit[0])
      | (nhit == 3'h1 & hit[0] & i_input_fitted_setting[1])
      | (nhit == 3'h1 & hit[3] & i_input_fitted_setting[2]);
  end

  assign neutral = ~i_dir_a & ~i_dir_b;

  always_comb
  begin
    stop_a_d = stop_a_q | (i_dir_a & hit[0]);
    slow_a_d = slow_a_q | (i_dir_a & hit[1]);
    stop_b_d = stop_b_q | (i_dir_b & hit[3]);
    slow_b_d = slow_b_q | (i_dir_b & hit[2]);
    if (neutral | i_dir_b)
    begin
      stop_a_d = i_dir_a & hit[0];
      slow_a_d = i_dir_a & hit[1];
    end
    if (neutral | i_dir_a)
    begin
      stop_b_d = i_dir_b & hit[3];
      slow_b_d = i_dir_b & hit[2];
    end
    fault_d = bad & (i_switch_arrangement_select != LSS_ARR_ACCEPT);
    ref_d = i_speed_ref_percent;
    if (i_dir_a & slow_a_d | i_dir_b & slow_b_d)
    begin
      if (ref_d > i_slowdown_speed_percent)
        ref_d = i_slowdown_speed_percent;
    end
    if (i_dir_a & stop_a_d | i_dir_b & stop_b_d | fault_d | neutral)
      ref_d = 7'h00;
    mode_d = mode_q;
    if (!i_accel_mode)
      mode_d = LSS_MODE_SPEED;
    else if (stop_a_d | slow_a_d | stop_b_d | slow_b_d | fault_d)
      mode_d = LSS_MODE_SPEED;
    else if (neutral)
      mode_d = LSS_MODE_RAMP;
    else
      mode_d = mode_q;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      stop_a_q <= LSS_LATCH_RESET;
      slow_a_q <= LSS_LATCH_RESET;
      stop_b_q <= LSS_LATCH_RESET;
      slow_b_q <= LSS_LATCH_RESET;
      fault_q <= LSS_LATCH_RESET;
      ref_q <= LSS_REF_RESET;
      mode_q <= LSS_MODE_RAMP;
    end
    else
    begin
      stop_a_q <= stop_a_d;
      slow_a_q <= slow_a_d;
      stop_b_q <= stop_b_d;
      slow_b_q <= slow_b_d;
      fault_q <= fault_d;
      ref_q <= ref_d;
      mode_q <= mode_d;
    end
  end

  // Active-low status, 1 means unrestricted
  assign o_stop_a_n = ~stop_a_q;
  assign o_slow_a_n = ~slow_a_q;
  assign o_stop_b_n = ~stop_b_q;
  assign o_slow_b_n = ~slow_b_q;
  assign o_fault = fault_q;
  assign o_speed_ref_percent = ref_q;
  // Speed control with retardation ramp handled downstream
  assign o_speed_mode = (mode_q == LSS_MODE_SPEED);

  a_stop_zero: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_dir_a & ~i_dir_b & hit[0]) |=> (o_speed_ref_percent == 7'h00))
    else $error("stop toward A did not zero reference");
  a_stop_b_zero: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_dir_b & ~i_dir_a & hit[3]) |=> (o_speed_ref_percent == 7'h00))
    else $error("stop toward B did not zero reference");
  a_slow_limit: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_dir_a & ~i_dir_b & hit[1]) |=>
    (o_speed_ref_percent <= $past(i_slowdown_speed_percent)))
    else $error("slow toward A not limited");
  a_latch_hold: assert property (@(posedge i_clk) disable iff (i_reset)
    (!o_stop_a_n & i_dir_a & ~i_dir_b) |=> !o_stop_a_n)
    else $error("stop A latch lost");
  a_latch_clear: assert property (@(posedge i_clk) disable iff (i_reset)
    neutral |=> (o_stop_a_n & o_slow_a_n & o_stop_b_n & o_slow_b_n))
    else $error("latch not cleared on neutral");
  a_fault_both: assert property (@(posedge i_clk) disable iff (i_reset)
    (hit[0] & hit[3] & i_switch_arrangement_select == LSS_ARR_NORMAL) |=> o_fault)
    else $error("both stops gave no fault");
  a_fault_stops: assert property (@(posedge i_clk) disable iff (i_reset)
    o_fault |-> (o_speed_ref_percent == 7'h00))
    else $error("fault did not stop motion");
  a_accept_mode: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_switch_arrangement_select == LSS_ARR_ACCEPT) |=> !o_fault)
    else $error("fault raised in accept mode");
  a_accel_hand: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_accel_mode & hit[0] & i_dir_a) |=> o_speed_mode)
    else $error("no hand-over to speed control");
  a_unfitted: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_input_fitted_setting[0] |-> !hit[0])
    else $error("unfitted switch seen as hit");

  // Pin level held out of reset long enough to pass both sync stages
  sequence s_stop_a_low;
    (!i_stop_a_pin && !i_reset) [*3];
  endsequence

  sequence s_stop_a_high;
    (i_stop_a_pin && !i_reset) [*3];
  endsequence

  sequence s_stop_b_low;
    (!i_stop_b_pin && !i_reset) [*3];
  endsequence

  // Stop B hit while moving toward B, then still moving toward B
  sequence s_stop_b_hit;
    i_dir_b && !i_dir_a && hit[3];
  endsequence

  sequence s_keep_b;
    i_dir_b && !i_dir_a;
  endsequence

  a_pin_hit_a: assert property (@(posedge i_clk) disable iff (i_reset)
    s_stop_a_low ##0 (i_input_fitted_setting[0] &&
    i_switch_arrangement_select != LSS_ARR_BYPASS) |-> hit[0])
    else $error("low stop A pin not seen as hit");

  a_pin_free_a: assert property (@(posedge i_clk) disable iff (i_reset)
    s_stop_a_high |-> !hit[0])
    else $error("high stop A pin seen as hit");

  a_pin_hit_b: assert property (@(posedge i_clk) disable iff (i_reset)
    s_stop_b_low ##0 (i_input_fitted_setting[3] &&
    i_switch_arrangement_select != LSS_ARR_BYPASS) |-> hit[3])
    else $error("low stop B pin not seen as hit");

  a_keep_after_b: assert property (@(posedge i_clk) disable iff (i_reset)
    s_stop_b_hit ##1 s_keep_b |=> !o_stop_b_n)
    else $error("stop B latch lost after hit");

  a_slow_b_limit: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_dir_b & ~i_dir_a & hit[2]) |=>
    (o_speed_ref_percent <= $past(i_slowdown_speed_percent)))
    else $error("slow toward B not limited");

  a_hold_slow_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (!o_slow_a_n & i_dir_a & ~i_dir_b) |=> !o_slow_a_n)
    else $error("slow A latch lost");

  a_hold_stop_b: assert property (@(posedge i_clk) disable iff (i_reset)
    (!o_stop_b_n & i_dir_b & ~i_dir_a) |=> !o_stop_b_n)
    else $error("stop B latch lost");

  a_hold_slow_b: assert property (@(posedge i_clk) disable iff (i_reset)
    (!o_slow_b_n & i_dir_b & ~i_dir_a) |=> !o_slow_b_n)
    else $error("slow B latch lost");

  a_clear_by_b: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_dir_b & ~i_dir_a) |=> (o_stop_a_n & o_slow_a_n))
    else $error("A latches kept while moving toward B");

  a_clear_by_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_dir_a & ~i_dir_b) |=> (o_stop_b_n & o_slow_b_n))
    else $error("B latches kept while moving toward A");

  a_fault_three: assert property (@(posedge i_clk) disable iff (i_reset)
    (nhit >= 3'h3 && i_switch_arrangement_select == LSS_ARR_NORMAL) |=> o_fault)
    else $error("three or more hits gave no fault");

  a_fault_cross: assert property (@(posedge i_clk) disable iff (i_reset)
    ((hit[1] & hit[3] | hit[2] & hit[0]) &&
    i_switch_arrangement_select == LSS_ARR_NORMAL) |=> o_fault)
    else $error("cross pair gave no fault");

  a_fault_slows: assert property (@(posedge i_clk) disable iff (i_reset)
    (hit[1] & hit[2] && i_switch_arrangement_select == LSS_ARR_NORMAL) |=> o_fault)
    else $error("both slow-downs gave no fault");

  a_alone_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (hit == 4'h1 && i_input_fitted_setting[1] && i_switch_arrangement_select == LSS_ARR_NORMAL)
    |=> o_fault)
    else $error("stop A alone gave no fault");

  a_alone_b: assert property (@(posedge i_clk) disable iff (i_reset)
    (hit == 4'h8 && i_input_fitted_setting[2] && i_switch_arrangement_select == LSS_ARR_NORMAL)
    |=> o_fault)
    else $error("stop B alone gave no fault");

  a_bypass_all: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_switch_arrangement_select == LSS_ARR_BYPASS) |-> (hit == 4'h0))
    else $error("switch seen in bypass arrangement");

  a_reset_clear: assert property (@(posedge i_clk)
    i_reset |=> (o_stop_a_n & o_slow_a_n & o_stop_b_n & o_slow_b_n & !o_fault &
    o_speed_ref_percent == LSS_REF_RESET))
    else $error("reset did not clear restrictions");

  a_speed_plain: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_accel_mode |=> o_speed_mode)
    else $error("speed control not selected outside acceleration mode");
endmodule // lss_limit_switch_supervisor

// File: lss_limit_switch_supervisor_bench.sv
// Purpose: Self-checking bench for the limit switch supervisor
// Assumes: Outputs settle three edges after a pin change
// Notes: Status word is ref, four flags, fault, speed mode
`timescale 1ns/100ps
module lss_limit_switch_supervisor_bench;
  import lss_pkg::*;
  localparam logic [6:0] req = 7'h50;
  localparam logic [6:0] slw = 7'h19;
  logic clk, rst, acc, sb, lb, la, sa, da, db;
  logic [3:0] hit, fit;
  logic [1:0] dir, arr;
  wire logic [12:0] st;
  int fail_count, samples_checked;
  logic [3:0] tab [11] = '{4'hf, 4'he, 4'hd, 4'hb, 4'h7, 4'ha, 4'h5, 4'h6, 4'h9, 4'h1, 4'h8};
  lss_switch_model i_sw (.i_hit(hit), .i_dir(dir), .o_stop_b_pin(sb), .o_slow_b_pin(lb),
    .o_slow_a_pin(la), .o_stop_a_pin(sa), .o_dir_a(da), .o_dir_b(db));
  lss_limit_switch_supervisor i_dut (.i_clk(clk), .i_reset(rst), .i_stop_b_pin(sb),
    .i_slow_b_pin(lb), .i_slow_a_pin(la), .i_stop_a_pin(sa), .i_input_fitted_setting(fit),
    .i_switch_arrangement_select(arr), .i_slowdown_speed_percent(slw), .i_accel_mode(acc),
    .i_dir_a(da), .i_dir_b(db), .i_speed_ref_percent(req), .o_speed_ref_percent(st[12:6]),
    .o_stop_a_n(st[5]), .o_slow_a_n(st[4]), .o_stop_b_n(st[3]), .o_slow_b_n(st[2]),
    .o_fault(st[1]), .o_speed_mode(st[0]));
  task chk(input logic [12:0] e);
    samples_checked++;
    if (st !== e)
    begin
      fail_count++;
      $display("ERROR %0t status %h expected %h", $time, st, e);
    end
  endtask
  task go(input logic [3:0] h, input logic [1:0] d);
    @(negedge clk);
    hit = h;
    dir = d;
    repeat (4) @(negedge clk);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task t_side_a;
    go(4'h2, 2'h1); chk({slw, 4'hb, 2'h1});
    go(4'h0, 2'h1); chk({slw, 4'hb, 2'h1});
    go(4'h0, 2'h0); chk({7'h0, 4'hf, 2'h1});
    go(4'h3, 2'h1); chk({7'h0, 4'h3, 2'h1});
    go(4'h3, 2'h2); chk({req, 4'hf, 2'h1});
  endtask
  task t_side_b;
    go(4'h4, 2'h2); chk({slw, 4'he, 2'h1});
    go(4'hc, 2'h2); chk({7'h0, 4'hc, 2'h1});
    go(4'h0, 2'h0);
  endtask
  task t_fault;
    foreach (tab[i])
    begin
      go(tab[i], 2'h0); chk({7'h0, 4'hf, 2'h3});
    end
    go(4'ha, 2'h1); chk({7'h0, 4'hb, 2'h3});
    go(4'h0, 2'h0);
  endtask
  task t_cfg;
    fit = 4'he;
    go(4'h1, 2'h1); chk({req, 4'hf, 2'h1});
    fit = 4'hd;
    go(4'h1, 2'h1); chk({7'h0, 4'h7, 2'h1});
    fit = 4'hf;
    arr = 2'h3;
    go(4'h9, 2'h0); chk({7'h0, 4'hf, 2'h1});
    arr = 2'h0;
    go(4'h1, 2'h1); chk({req, 4'hf, 2'h1});
    arr = 2'h1;
    go(4'h0, 2'h0);
  endtask
  task t_accel;
    acc = 1'b1;
    go(4'h0, 2'h0); chk({7'h0, 4'hf, 2'h0});
    go(4'h2, 2'h1); chk({slw, 4'hb, 2'h1});
  endtask
  task t_reset;
    @(negedge clk);
    rst = 1'b1;
    hit = 4'h0;
    dir = 2'h0;
    @(negedge clk);
    chk({7'h0, 4'hf, 2'h0});
    rst = 1'b0;
    acc = 1'b0;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
  initial
  begin
    {rst, acc, hit, dir, fit, arr} = {1'b1, 1'b0, 4'h0, 2'h0, 4'hf, 2'h1};
    repeat (6) @(negedge clk);
    chk({7'h0, 4'hf, 2'h0});
    rst = 1'b0;
    t_side_a();
    t_side_b();
    t_fault();
    t_cfg();
    t_accel();
    t_reset();
    end_of_test();
  end
endmodule // lss_limit_switch_supervisor_bench

// File: lss_pkg.sv
// Purpose: Shared constants for the travel limit switch supervisor
// Assumes: Single 250 MHz clock, synchronous active-high reset
// Notes: Switch arrangement codes and reset values
package lss_pkg;
  localparam int LSS_CLK_MHZ = 250;
  localparam logic [1:0] LSS_ARR_BYPASS = 2'h0;
  localparam logic [1:0] LSS_ARR_NORMAL = 2'h1;
  localparam logic [1:0] LSS_ARR_ACCEPT = 2'h3;
  localparam logic LSS_FLAG_RESET = 1'h1;
  localparam logic LSS_LATCH_RESET = 1'h0;
  localparam logic [6:0] LSS_REF_RESET = 7'h00;
  localparam logic [3:0] LSS_SYNC_RESET = 4'hf;
  localparam logic [6:0] LSS_PCT_FULL = 7'h64;
  typedef enum logic [1:0] {
    LSS_MODE_SPEED = 2'h1,
    LSS_MODE_RAMP = 2'h2
  } lss_mode_t;
endpackage

// File: lss_switch_model.sv
// Purpose: Limit switches and master switch facing the supervisor
// Assumes: Hit order stop B, slow B, slow A, stop A
// Notes: A free switch carries voltage
`timescale 1ns/100ps
module lss_switch_model
(
  // Commands
  input wire logic [3:0] i_hit,
  input wire logic [1:0] i_dir,
  // Pins
  output logic o_stop_b_pin,
  output logic o_slow_b_pin,
  output logic o_slow_a_pin,
  output logic o_stop_a_pin,
  output logic o_dir_a,
  output logic o_dir_b
);
  assign {o_stop_b_pin, o_slow_b_pin, o_slow_a_pin, o_stop_a_pin} = ~i_hit;
  assign {o_dir_b, o_dir_a} = i_dir;
endmodule // lss_switch_model
